// file: bfss_consts.vh
// Timing constants and field positions of the boost fault and soft-start supervisor
`ifndef BFSS_CONSTS_VH
`define BFSS_CONSTS_VH
// ==========================================
// Clock
`define BFSS_CLK_HZ 50000000
`define BFSS_CLK_NS 20
// ==========================================
// Soft start: 20 ms ramp to 0.75 V, reference as 0..750 mV code
`define BFSS_SS_TIME_MS 20
`define BFSS_SS_END_MV 750
`define BFSS_SS_CYCLES (`BFSS_SS_TIME_MS * (`BFSS_CLK_HZ / 1000))
// ==========================================
// Hiccup cool-down 60 ms and overcurrent pulse count of 8
`define BFSS_COOL_TIME_MS 60
`define BFSS_COOL_CYCLES (`BFSS_COOL_TIME_MS * (`BFSS_CLK_HZ / 1000))
`define BFSS_OC_PULSES 8
// ==========================================
// Sync mode change delay in oscillator periods; ten periods fits every rate
`define BFSS_SYNC_DLY_PERIODS 10
// Free-running oscillator period default, 300 kHz
`define BFSS_OSC_PERIOD 167
// Sync edge missing for this many periods drops back to free-run
`define BFSS_SYNC_LOSS_PERIODS 2
// ==========================================
// Status vector bit positions
`define BFSS_ST_SUPPLY_UNDERVOLTAGE_LOCKOUT 0
`define BFSS_ST_OVP 1
`define BFSS_ST_HOT 2
`define BFSS_ST_STBY 3
`define BFSS_ST_HICC 4
`define BFSS_ST_SS 5
`define BFSS_ST_SYNC 6
`define BFSS_ST_RUN 7
`endif

// file: bfss_sync2.v
// Two-flop synchroniser bank for asynchronous comparator and pin inputs
`timescale 1ns/100ps
module bfss_sync2 #(
  parameter W = 6
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] meta_q;

  // ==========================================
  // Synchroniser: the first stage feeds only the second
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= {W{1'b0}};
      q_out <= {W{1'b0}};
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// file: bfss_supervisor.v
// Switch drive gating, protection sequencing and soft start of the boost supervisor
//
// Contract
// [RQ1] Gate held off while feedback is above the overvoltage level; resumes after.
// [RQ2] Supply rising above release level ends lockout and starts operation.
// [RQ3] Supply below detect level enters lockout and stops everything.
// [RQ4] Overheat indication halts switching.
// [RQ5] Overheat clearing restarts switching through a soft start.
// [RQ6] Switch current at limit ends the on-time of the current cycle.
// [RQ7] Eight consecutive limited pulses with low feedback force hiccup off.
// [RQ8] Hiccup waits 60 ms cool-down, then restarts with soft start.
// [RQ9] Soft start ramps reference from zero to 0.75 V over 20 ms.
// [RQ10] Soft start follows lockout, overheat, standby and cool-down exits.
// [RQ11] Enable below standby threshold puts the device in standby.
// [RQ12] Open enable reads low, so it means standby.
// [RQ13] External sync wave stays in 0.9x..1.7x frequency, pulses at least 25 ns.
// [RQ14] In sync mode each cycle starts on the sync rising edge.
// [RQ15] Changing between free-run and sync waits a transition delay.
// [RQ16] Enable high runs normally; low or open stays in standby.
// [RQ17] Any stopping condition holds the gate drive low.
// [RQ18] Pulse count clears on a clean cycle or when feedback is not low.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "bfss_consts.vh"
module bfss_supervisor #(
  parameter SS_CYCLES = `BFSS_SS_CYCLES,
  parameter COOL_CYCLES = `BFSS_COOL_CYCLES
) (
  // Clock and reset (reset enters supply lockout; SUPPLY_OK_IN releases it)
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  // Comparator outputs, all asynchronous
  input wire SUPPLY_OK_IN,
  input wire FB_OVER_IN,
  input wire FB_LOW_IN,
  input wire JUNCTION_HOT_IN,
  input wire SWITCH_OC_IN,
  input wire RUN_EN_IN,
  // External synchronising clock pin
  input wire SYNC_CLK_IN,
  // PWM comparator: on-time end request from the regulation loop
  input wire PWM_END_IN,
  // APB slave
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  // Outputs
  output reg GATE_DRIVE_OUT,
  output reg [9:0] SS_REF_MV_OUT,
  output reg SOFTSTART_ACTIVE_OUT,
  output reg SYNC_MODE_OUT
);
  // ==========================================
  // Register map
  localparam [11:0] ADDR_CTRL = 12'h000;
  localparam [11:0] ADDR_STAT = 12'h004;
  localparam [11:0] ADDR_PERIOD = 12'h008;
  localparam [11:0] ADDR_OCCNT = 12'h00c;

  // Supervisor states
  localparam [2:0] ST_LOCK = 3'h0;
  localparam [2:0] ST_STBY = 3'h1;
  localparam [2:0] ST_SOFT = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_HOT = 3'h4;
  localparam [2:0] ST_COOL = 3'h5;

  // Ramp step; constants sized to the registers they meet
  localparam [31:0] SS_STEP = SS_CYCLES / `BFSS_SS_END_MV;
  localparam [9:0] SS_END = 10'd`BFSS_SS_END_MV;
  localparam [3:0] OC_MAX = 4'd`BFSS_OC_PULSES;
  localparam [15:0] OSC_RESET = 16'd`BFSS_OSC_PERIOD;

  // ==========================================
  // Input synchronisation
  wire [6:0] s_w;
  bfss_sync2 #(.W(7)) u_sync (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RST_N_IN),
    .d_in({SYNC_CLK_IN, RUN_EN_IN, SWITCH_OC_IN, JUNCTION_HOT_IN, FB_LOW_IN,
      FB_OVER_IN, SUPPLY_OK_IN}),
    .q_out(s_w)
  );
  wire supply_ok = s_w[0];
  wire fb_over = s_w[1];
  wire fb_low = s_w[2];
  wire hot = s_w[3];
  wire oc = s_w[4];
  wire run_en = s_w[5];
  wire sync_lvl = s_w[6];

  // Sequencer, ramp, pulse-limit, oscillator and mode-change state
  reg [2:0] state_q;
  reg [31:0] tmr_q;
  reg [9:0] ref_q;
  reg [31:0] step_q;
  reg [3:0] oc_cnt_q;
  reg cyc_oc_q;
  reg gate_q;
  reg [15:0] osc_q;
  reg [15:0] period_q;
  reg sync_en_q;
  reg sync_prev_q;
  reg sync_mode_q;
  reg [31:0] sync_tmr_q;
  reg [15:0] since_edge_q;
  reg sw_stop_q;

  // Sync edge detect; the previous level resets low, the idle level of the pin
  wire sync_rise = sync_lvl & ~sync_prev_q;
  // Loss and delay scale with the set period so slow rates are not dropped;
  // edge age saturates, so periods beyond half its range never lose sync
  wire sync_seen = {16'h0000, since_edge_q} <
    {16'h0000, period_q} * `BFSS_SYNC_LOSS_PERIODS;
  // Ten periods lands inside the allowed delay window at every oscillator rate
  wire [31:0] sync_dly = {16'h0000, period_q} * `BFSS_SYNC_DLY_PERIODS;
  wire osc_wrap = (osc_q >= period_q - 16'h0001);
  // Cycle start: sync edge in sync mode, own oscillator otherwise
  wire cyc_start = sync_mode_q ? sync_rise : osc_wrap; // [RQ14]
  wire switching = (state_q == ST_SOFT) || (state_q == ST_RUN);

  // ==========================================
  // Mode change with delay; a wanted mode must persist through it
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync_prev_q <= 1'b0;
      since_edge_q <= 16'hffff;
      sync_mode_q <= 1'b0;
      sync_tmr_q <= 32'h0;
    end else begin
      sync_prev_q <= sync_lvl;
      if (sync_rise) begin
        since_edge_q <= 16'h0000;
      end else if (since_edge_q != 16'hffff) begin
        since_edge_q <= since_edge_q + 16'h0001;
      end
      // Timer restarts whenever the wanted mode matches the present one
      if ((sync_en_q & sync_seen) == sync_mode_q) begin
        sync_tmr_q <= 32'h0;
      end else if (sync_tmr_q >= sync_dly - 32'h1) begin
        sync_mode_q <= ~sync_mode_q; // [RQ15]
        sync_tmr_q <= 32'h0;
      end else begin
        sync_tmr_q <= sync_tmr_q + 32'h1; // [RQ15]
      end
    end
  end

  // ==========================================
  // Free-running oscillator, restarted at each cycle start
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      osc_q <= 16'h0000;
    end else if (cyc_start) begin
      osc_q <= 16'h0000;
    end else begin
      osc_q <= osc_q + 16'h0001;
    end
  end

  // ==========================================
  // Supervisor sequence
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_LOCK;
      tmr_q <= 32'h0;
      ref_q <= 10'h000;
      step_q <= 32'h0;
    end else begin
      if (!supply_ok) begin
        state_q <= ST_LOCK; // [RQ3]
        ref_q <= 10'h000;
      end else begin
        case (state_q)
          ST_LOCK: begin
            state_q <= ST_STBY; // [RQ2]
          end
          ST_STBY: begin
            ref_q <= 10'h000;
            // Open enable pin reads low through the pull-down
            if (run_en && !sw_stop_q) begin // [RQ11] [RQ12] [RQ16]
              state_q <= ST_SOFT; // [RQ10]
              step_q <= 32'h0;
            end
          end
          ST_SOFT: begin
            if (step_q >= SS_STEP - 32'h1) begin
              step_q <= 32'h0;
              if (ref_q >= SS_END - 10'h001) begin
                state_q <= ST_RUN;
                ref_q <= SS_END;
              end else begin
                ref_q <= ref_q + 10'h001; // [RQ9]
              end
            end else begin
              step_q <= step_q + 32'h1;
            end
          end
          ST_RUN: begin
            ref_q <= SS_END;
          end
          ST_HOT: begin
            ref_q <= 10'h000;
            if (!hot) begin
              state_q <= ST_SOFT; // [RQ5]
              step_q <= 32'h0;
            end
          end
          ST_COOL: begin
            ref_q <= 10'h000;
            if (tmr_q >= COOL_CYCLES - 1) begin
              tmr_q <= 32'h0;
              state_q <= ST_SOFT; // [RQ8]
              step_q <= 32'h0;
            end else begin
              tmr_q <= tmr_q + 32'h1;
            end
          end
          default: begin
            state_q <= ST_LOCK;
          end
        endcase
        // Exit paths from switching; priority: overheat, standby, hiccup
        if (switching) begin
          if (hot) begin
            state_q <= ST_HOT; // [RQ4]
          end else if (!run_en || sw_stop_q) begin
            state_q <= ST_STBY; // [RQ11]
          end else if (oc_cnt_q == OC_MAX) begin
            state_q <= ST_COOL; // [RQ7]
            tmr_q <= 32'h0;
          end
        end
      end
    end
  end

  // ==========================================
  // Pulse-by-pulse current limit and consecutive-pulse counter
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      gate_q <= 1'b0;
      cyc_oc_q <= 1'b0;
      oc_cnt_q <= 4'h0;
    end else begin
      if (!switching || fb_over) begin
        gate_q <= 1'b0; // [RQ1] [RQ17]
      end else if (oc) begin
        gate_q <= 1'b0; // [RQ6]
      end else if (cyc_start) begin
        gate_q <= 1'b1;
      end else if (PWM_END_IN) begin
        gate_q <= 1'b0;
      end
      if (!switching || !fb_low) begin
        oc_cnt_q <= 4'h0; // [RQ18]
        cyc_oc_q <= 1'b0;
      end else if (cyc_start) begin
        // Score the cycle that just ended
        if (cyc_oc_q || oc) begin
          // Saturate so a long overload cannot wrap the count
          if (oc_cnt_q != OC_MAX) begin
            oc_cnt_q <= oc_cnt_q + 4'h1; // [RQ7]
          end
        end else begin
          oc_cnt_q <= 4'h0; // [RQ18]
        end
        cyc_oc_q <= 1'b0;
      end else if (oc && gate_q) begin
        cyc_oc_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // APB slave, zero wait states
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PRDATA_OUT <= 32'h0;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      sync_en_q <= 1'b0;
      sw_stop_q <= 1'b0;
      period_q <= OSC_RESET;
    end else begin
      PREADY_OUT <= PSEL_IN & ~PENABLE_IN;
      PSLVERR_OUT <= 1'b0;
      // Writes land only at the completing edge, where ready is seen high
      if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN) begin
        if (PADDR_IN == ADDR_CTRL) begin
          sync_en_q <= PWDATA_IN[0];
          sw_stop_q <= PWDATA_IN[1];
        end
        // A period under two clocks would stall the oscillator, so it is ignored
        if (PADDR_IN == ADDR_PERIOD && PWDATA_IN[15:0] > 16'h0001) begin
          period_q <= PWDATA_IN[15:0];
        end
      end
      // Reads decode in setup so the data stands through the access cycle
      if (PSEL_IN && !PENABLE_IN) begin
        PRDATA_OUT <= 32'h0;
        case (PADDR_IN)
          ADDR_CTRL: begin
            PRDATA_OUT <= {30'h0, sw_stop_q, sync_en_q};
          end
          ADDR_STAT: begin
            PRDATA_OUT <= {24'h0, state_q == ST_RUN, sync_mode_q, state_q == ST_SOFT,
              state_q == ST_COOL, state_q == ST_STBY, state_q == ST_HOT, fb_over,
              state_q == ST_LOCK};
          end
          ADDR_PERIOD: begin
            PRDATA_OUT <= {16'h0, period_q};
          end
          ADDR_OCCNT: begin
            PRDATA_OUT <= {28'h0, oc_cnt_q};
          end
          default: begin
            PSLVERR_OUT <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================
  // Registered outputs
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      GATE_DRIVE_OUT <= 1'b0;
      SS_REF_MV_OUT <= 10'h000;
      SOFTSTART_ACTIVE_OUT <= 1'b0;
      SYNC_MODE_OUT <= 1'b0;
    end else begin
      GATE_DRIVE_OUT <= gate_q & switching & ~fb_over & ~oc; // [RQ17]
      SS_REF_MV_OUT <= ref_q;
      SOFTSTART_ACTIVE_OUT <= (state_q == ST_SOFT);
      SYNC_MODE_OUT <= sync_mode_q;
    end
  end
endmodule

// file: bfss_supervisor_props.sv
// Port-level assertions for the boost fault and soft-start supervisor
`timescale 1ns/100ps
// ==========================================
// Checker
module bfss_chk (
  // Clock, reset, comparator and APB inputs
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire SUPPLY_OK_IN,
  input wire FB_OVER_IN,
  input wire JUNCTION_HOT_IN,
  input wire SWITCH_OC_IN,
  input wire RUN_EN_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  // Watched outputs
  input wire PREADY_OUT,
  input wire GATE_DRIVE_OUT,
  input wire [9:0] SS_REF_MV_OUT,
  input wire SOFTSTART_ACTIVE_OUT
);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Stop conditions held past their input path, three cycles for overvoltage and current limit, four for the rest, must keep the gate low
  chk_ovp_gate_off: assert property (FB_OVER_IN [*5] |=> !GATE_DRIVE_OUT)
    else $error("gate on in overvoltage");
  chk_hot_gate_off: assert property (JUNCTION_HOT_IN [*5] |=> !GATE_DRIVE_OUT)
    else $error("gate on when hot");
  chk_lock_gate_off: assert property ((!SUPPLY_OK_IN) [*5] |=> !GATE_DRIVE_OUT)
    else $error("gate on in lockout");
  chk_stby_gate_off: assert property ((!RUN_EN_IN) [*5] |=> !GATE_DRIVE_OUT)
    else $error("gate on in standby");
  chk_oc_gate_off: assert property (SWITCH_OC_IN [*5] |=> !GATE_DRIVE_OUT)
    else $error("gate on at current limit");
  // Reference never passes the end level and climbs at most one step per cycle
  chk_ss_ref_range: assert property (SS_REF_MV_OUT <= 10'h2ee)
    else $error("reference above end level");
  chk_ss_ramp_step: assert property (SOFTSTART_ACTIVE_OUT && $past(SOFTSTART_ACTIVE_OUT)
    |-> SS_REF_MV_OUT - $past(SS_REF_MV_OUT) <= 10'h001) else $error("ramp not gradual");
  // Zero wait states: setup cycle is answered in the access cycle
  chk_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("no ready in access phase");
endmodule

bind bfss_supervisor bfss_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN),
  .SUPPLY_OK_IN(SUPPLY_OK_IN), .FB_OVER_IN(FB_OVER_IN), .JUNCTION_HOT_IN(JUNCTION_HOT_IN),
  .SWITCH_OC_IN(SWITCH_OC_IN), .RUN_EN_IN(RUN_EN_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT), .GATE_DRIVE_OUT(GATE_DRIVE_OUT),
  .SS_REF_MV_OUT(SS_REF_MV_OUT), .SOFTSTART_ACTIVE_OUT(SOFTSTART_ACTIVE_OUT));

// file: bfss_sync_src.sv
// Model of the external sync square-wave source
`timescale 1ns/100ps
// ==========================================
// Sync source, started 7 ns in; edges sit 3 ns before a clock rise while the period is a multiple of 20 ns
module bfss_sync_src (
  // Control
  input wire en_in,
  input wire [15:0] period_ns_in,
  // Sync pin
  output reg sync_out
);
  // 60 ns high pulses, far above the minimum width; idles low when disabled
  initial begin
    sync_out = 1'b0;
    #7;
    forever begin
      if (en_in) begin
        sync_out = 1'b1;
        #60;
        sync_out = 1'b0;
        #(period_ns_in - 16'd60);
      end else begin
        #20;
      end
    end
  end
endmodule

// file: boost_fault_and_softstart_supervisor_bench.sv
// Self-checking bench for the boost fault and soft-start supervisor
`timescale 1ns/100ps
// ==========================================
// Bench top
module boost_fault_and_softstart_supervisor_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sup_ok, fb_over, fb_low, hot, oc, run_en, sync_en, psel, pen, pwr, e;
  logic pwm_end = 1'b0, gate_d = 1'b0, sync_d = 1'b0, win = 1'b0;
  logic sync_clk, gate, ss_act, sync_mode, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, p;
  logic [9:0] ss_ref;
  int num_errors = 0, n_compared = 0, cyc = 0, rises = 0, bad = 0, age = 0, base, t, k;
  // Short soft-start and cool-down counts keep the run brief
  bfss_supervisor #(.SS_CYCLES(7500), .COOL_CYCLES(500)) u_dut (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .SUPPLY_OK_IN(sup_ok), .FB_OVER_IN(fb_over),
    .FB_LOW_IN(fb_low), .JUNCTION_HOT_IN(hot), .SWITCH_OC_IN(oc), .RUN_EN_IN(run_en),
    .SYNC_CLK_IN(sync_clk), .PWM_END_IN(pwm_end), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .GATE_DRIVE_OUT(gate),
    .SS_REF_MV_OUT(ss_ref), .SOFTSTART_ACTIVE_OUT(ss_act), .SYNC_MODE_OUT(sync_mode));
  // Sync at 1.25 times the oscillator rate
  bfss_sync_src u_sync (.en_in(sync_en), .period_ns_in(p[15:0] * 16'd16), .sync_out(sync_clk));
  initial begin
    forever #10 clk = ~clk;
  end
  // Gate edges, age since sync edge, random on-time ends and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    gate_d <= gate;
    sync_d <= sync_clk;
    age <= (sync_clk && !sync_d) ? 0 : age + 1;
    if (gate && !gate_d) rises <= rises + 1;
    if (gate && !gate_d && win && age > 6) bad <= bad + 1;
    pwm_end <= ($urandom_range(7) == 0);
    if (cyc == 60000) begin
      num_errors++;
      end_sim;
    end
  end
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Bounded wait for soft start (sel 0) or sync mode (sel 1) to reach a level
  task wait_on(input logic sel, input logic lvl, input int lim);
    t = 0;
    while ((sel ? sync_mode : ss_act) !== lvl && t < lim) begin
      @(posedge clk);
      t++;
    end
    chk("wait level", {31'h0, lvl}, {31'h0, sel ? sync_mode : ss_act});
  endtask
  task end_sim;
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(94508));
    {sup_ok, fb_over, fb_low, hot, oc, run_en, sync_en, psel, pen, pwr} = 10'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    // Oscillator period kept inside the supported rate span, 1 MHz and slower
    p = 32'h32 + $urandom_range(20);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // Registers: lockout flag, period default, short-period refusal, unmapped place
    apb(1'b0, 12'h004, 32'h0);
    chk("lockout", 32'h1, {31'h0, r[0]});
    apb(1'b0, 12'h008, 32'h0);
    chk("period", 32'ha7, r);
    apb(1'b1, 12'h008, p);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk("period", p, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, r);
    // Supply up with enable open stays idle, enable high then soft-starts
    sup_ok <= 1'b1;
    base = rises;
    repeat (200) @(posedge clk);
    chk("standby rises", 32'h0, rises - base);
    run_en <= 1'b1;
    wait_on(1'b0, 1'b1, 20);
    wait_on(1'b0, 1'b0, 7600);
    chk("ss length", 32'h1, {31'h0, t >= 7490 && t <= 7520});
    chk("ss end", 32'h2ee, {22'h0, ss_ref});
    // Overvoltage blocks the gate, which resumes after
    fb_over <= 1'b1;
    repeat (5) @(posedge clk);
    base = rises;
    repeat (300) @(posedge clk);
    chk("ovp rises", 32'h0, rises - base);
    fb_over <= 1'b0;
    base = rises;
    repeat (3 * p) @(posedge clk);
    chk("ovp resume", 32'h1, {31'h0, rises - base >= 2});
    // Current limit without low feedback never trips hiccup; with it, cool-down
    oc <= 1'b1;
    repeat (5) @(posedge clk);
    base = rises;
    repeat (30 * p) @(posedge clk);
    chk("oc rises", 32'h0, rises - base);
    chk("no hiccup", 32'h0, {31'h0, ss_act});
    fb_low <= 1'b1;
    wait_on(1'b0, 1'b1, 8 * p + 600);
    chk("cool time", 32'h1, {31'h0, t >= 7 * p + 500 && t <= 8 * p + 520});
    {oc, fb_low} <= 2'h0;
    wait_on(1'b0, 1'b0, 7600);
    // Overheat, standby and lockout each stop and then soft-start again
    for (k = 0; k < 3; k++) begin
      hot <= (k == 0);
      run_en <= (k != 1);
      sup_ok <= (k != 2);
      repeat (5) @(posedge clk);
      base = rises;
      repeat (100) @(posedge clk);
      chk("fault rises", 32'h0, rises - base);
      {hot, run_en, sup_ok} <= 3'h3;
      wait_on(1'b0, 1'b1, 20);
      wait_on(1'b0, 1'b0, 7600);
    end
    // Sync mode waits the transition delay, then cycles follow sync edges;
    // at a 1 MHz rate the change may take 3 to 12 us, 150 to 600 clocks
    p <= 32'h32;
    apb(1'b1, 12'h008, 32'h32);
    sync_en <= 1'b1;
    apb(1'b1, 12'h000, 32'h1);
    repeat (140) @(posedge clk);
    chk("sync early", 32'h0, {31'h0, sync_mode});
    wait_on(1'b1, 1'b1, 600);
    chk("sync delay", 32'h1, {31'h0, t + 140 <= 600});
    repeat (5) @(posedge clk);
    win = 1'b1;
    base = rises;
    repeat (20 * p) @(posedge clk);
    win = 1'b0;
    chk("sync aligned", 32'h0, bad);
    chk("sync rises", 32'h1, {31'h0, rises - base >= 10});
    sync_en <= 1'b0;
    wait_on(1'b1, 1'b0, 800);
    chk("sync exit", 32'h1, {31'h0, t >= 150 && t <= 2 * p + 600});
    end_sim;
  end
endmodule
